/* hdl/ext_bus_pins.sv */
// general ports 0 to 4 with external memory bus mapping
`timescale 1ns/100ps

// Behaviour
// - low level on the reset input puts every register except the pin and hold synchronisers into its reset state.
// - width select low gives 16-bit data bus, high gives 8-bit.
// - each port has a per-bit direction register choosing input or output.
// - single-chip mode: input pull-ups enabled by software per four-bit group.
// - expansion mode: pull-up selection unavailable on every port.
// - separate bus: port zero carries data 0-7, port one data 8-15.
// - separate bus: port two outputs address 0-7, port three address 8-15.
// - 8-bit multiplexed: port two shares address 0-7 with data 0-7.
// - 16-bit multiplexed: port two A0 dedicated, A1-7 shared with D0-6.
// - 16-bit multiplexed: port three shares A8 with D7, A9-15 address only.
// - port four gives four chip selects and address 16-19.
// - the chip select of the targeted access space is asserted per cycle.
// - port one pins can be chosen as external interrupt inputs.
// - split strobes: low write for even, high write for odd, read strobe.
// - single strobe: one write strobe, byte-high enable low on odd address.
// - address latch enable marks the multiplexed address phase.
// - in expansion mode, while hold request is low, device holds after any current cycle and drives acknowledge low.
module ext_bus_pins (
  input  wire logic         i_clock,            // 100 MHz clock
  input  wire logic         i_rstn,             // sync reset, active low
  input  wire logic         i_bus_width_8,      // width select pin, high = 8-bit
  input  wire logic         i_expansion_mode,   // memory expansion mode
  input  wire logic         i_mux_bus,          // multiplexed bus form
  input  wire logic         i_single_strobe,    // write plus byte-high enable strobes
  input  wire logic         i_hold_req_n,       // hold request pin, active low
  input  wire logic         i_cyc_start,        // cpu bus cycle request pulse
  input  wire logic         i_cyc_write,        // request is a write
  input  wire logic         i_cyc_word,         // request is a 16-bit word
  input  wire logic [19:0]  i_cyc_addr,         // request address
  input  wire logic [15:0]  i_cyc_wdata,        // request write data
  input  wire logic [1:0]   i_cyc_space,        // targeted chip select space
  input  wire logic         i_cfg_we,           // port config write pulse
  input  wire logic [2:0]   i_cfg_port,         // port index 0 to 4
  input  wire logic [7:0]   i_cfg_dir,          // direction bits, 1 = output
  input  wire logic [7:0]   i_cfg_data,         // output latch value
  input  wire logic [1:0]   i_cfg_pullup,       // nibble pull-up enables
  input  wire logic [7:0]   i_irq_sel,          // port one pins as interrupts
  input  wire logic [39:0]  i_pin_in,           // pin levels, port n at [8n+7:8n]
  output logic [39:0]       o_pin_out,          // pin output levels
  output logic [39:0]       o_pin_oe,           // pin output enables
  output logic [39:0]       o_pin_pullup,       // pin pull-up enables
  output logic [39:0]       o_port_read,        // synchronised pin levels
  output logic [7:0]        o_ext_irq,          // interrupt request levels
  output logic              o_read_strobe_n,    // read strobe, active low
  output logic              o_low_byte_write_strobe_n,  // low write / single write
  output logic              o_high_byte_write_strobe_n, // high write strobe
  output logic              o_byte_high_enable_n,       // byte-high enable
  output logic              o_ale,              // address latch enable
  output logic              o_hold_acknowledge_output_n, // hold acknowledge
  output logic              o_cyc_busy,         // bus cycle in progress
  output logic              o_cyc_done,         // cycle done pulse
  output logic [15:0]       o_cyc_rdata         // read data of last read cycle
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_HOLD
  } bus_state_e;

  localparam int NP = 5;

  // per-port configuration
  logic [7:0]  dir_ff    [NP];
  logic [7:0]  nxt_dir   [NP];
  logic [7:0]  data_ff   [NP];
  logic [7:0]  nxt_data  [NP];
  logic [1:0]  pu_ff     [NP];
  logic [1:0]  nxt_pu    [NP];
  logic [39:0] sync1_ff;
  logic [39:0] sync2_ff;
  logic        hold_s1_ff;
  logic        hold_s2_ff;

  // bus cycle state
  bus_state_e  state_ff;
  bus_state_e  nxt_state;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  logic [19:0] addr_ff;
  logic [19:0] nxt_addr;
  logic [15:0] wdat_ff;
  logic [15:0] nxt_wdat;
  logic        wr_ff;
  logic        nxt_wr;
  logic        word_ff;
  logic        nxt_word;
  logic [1:0]  space_ff;
  logic [1:0]  nxt_space;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        done_ff;
  logic        nxt_done;

  // registered pin drive
  logic [39:0] pout_ff;
  logic [39:0] nxt_pout;
  logic [39:0] poe_ff;
  logic [39:0] nxt_poe;
  logic [39:0] ppu_ff;
  logic [39:0] nxt_ppu;
  logic [7:0]  irq_ff;
  logic [7:0]  nxt_irq;
  logic [6:0]  strb_ff;
  logic [6:0]  nxt_strb;

  function automatic logic [3:0] cs_decode(input logic [1:0] space);
    cs_decode = ext_bus_pkg::CS_IDLE & ~(4'h1 << space);
  endfunction

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      nxt_dir[p]  = dir_ff[p];
      nxt_data[p] = data_ff[p];
      nxt_pu[p]   = pu_ff[p];
      if (i_cfg_we && i_cfg_port == 3'(p)) begin
        nxt_dir[p]  = i_cfg_dir;
        nxt_data[p] = i_cfg_data;
        nxt_pu[p]   = i_cfg_pullup;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    sync1_ff   <= i_pin_in;
    sync2_ff   <= sync1_ff;
    hold_s1_ff <= i_hold_req_n;
    hold_s2_ff <= hold_s1_ff;
    for (int p = 0; p < NP; p++) begin
      if (!i_rstn) begin
        dir_ff[p]  <= ext_bus_pkg::DIR_RESET;
        data_ff[p] <= ext_bus_pkg::PORT_RESET;
        pu_ff[p]   <= ext_bus_pkg::PULLUP_RESET;
      end else begin
        dir_ff[p]  <= nxt_dir[p];
        data_ff[p] <= nxt_data[p];
        pu_ff[p]   <= nxt_pu[p];
      end
    end
  end

  // bus cycle sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_addr  = addr_ff;
    nxt_wdat  = wdat_ff;
    nxt_wr    = wr_ff;
    nxt_word  = word_ff;
    nxt_space = space_ff;
    nxt_rdata = rdata_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (!i_expansion_mode) begin
          nxt_state = ST_IDLE;
        end else if (!hold_s2_ff) begin
          nxt_state = ST_HOLD;
        end else if (i_cyc_start) begin
          nxt_addr  = i_cyc_addr;
          nxt_wdat  = i_cyc_wdata;
          nxt_wr    = i_cyc_write;
          nxt_word  = i_cyc_word && !i_bus_width_8;
          nxt_space = i_cyc_space;
          nxt_cnt   = 2'(ext_bus_pkg::ALE_CYCLES - 1);
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (cnt_ff == ext_bus_pkg::CNT_ZERO) begin
          nxt_cnt   = 2'(ext_bus_pkg::STROBE_CYCLES - 1);
          nxt_state = ST_STROBE;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      ST_STROBE: begin
        if (cnt_ff == ext_bus_pkg::CNT_ZERO) begin
          if (!wr_ff) begin
            nxt_rdata = rd_sample();
          end
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      ST_HOLD: begin
        if (hold_s2_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // read data from pins for the current bus form
  // bus data answers our own strobe, so it is taken straight off the pins
  function automatic logic [15:0] rd_sample();
    logic [15:0] d;
    d = 16'h0000;
    if (!i_mux_bus) begin
      d = {i_pin_in[15:8], i_pin_in[7:0]};
    end else if (i_bus_width_8) begin
      d[7:0] = i_pin_in[23:16];
    end else begin
      d[6:0] = i_pin_in[23:17];
      d[7]   = i_pin_in[24];
    end
    if (addr_ff[0] && !word_ff && !i_mux_bus && !i_bus_width_8) begin
      d[7:0] = d[15:8];
    end
    return d;
  endfunction

  // pin multiplexing
  always_comb begin
    logic        bus_on;
    logic        dphase;
    logic [15:0] wd;
    bus_on   = i_expansion_mode && state_ff != ST_HOLD;
    dphase   = state_ff == ST_STROBE;
    wd       = (addr_ff[0] && !word_ff) ? {wdat_ff[7:0], wdat_ff[7:0]} : wdat_ff;
    for (int p = 0; p < NP; p++) begin
      nxt_pout[8*p +: 8] = data_ff[p];
      nxt_poe[8*p +: 8]  = dir_ff[p];
      for (int n = 0; n < 2; n++) begin
        nxt_ppu[8*p + 4*n +: 4] = ~dir_ff[p][4*n +: 4] & {4{pu_ff[p][n] & ~i_expansion_mode}};
      end
    end
    nxt_irq = i_irq_sel & ~dir_ff[1] & sync2_ff[15:8];
    if (bus_on) begin
      nxt_ppu[39:0] = 40'h0;
      if (!i_mux_bus) begin
        nxt_pout[7:0]   = wd[7:0];
        nxt_poe[7:0]    = {8{dphase && wr_ff}};
        nxt_poe[15:8]   = {8{dphase && wr_ff && !i_bus_width_8}};
        nxt_pout[15:8]  = wd[15:8];
        nxt_pout[23:16] = addr_ff[7:0];
        nxt_pout[31:24] = addr_ff[15:8];
        nxt_poe[31:16]  = 16'hffff;
      end else if (i_bus_width_8) begin
        nxt_pout[23:16] = dphase ? wd[7:0] : addr_ff[7:0];
        nxt_poe[23:16]  = {8{!dphase || wr_ff}};
        nxt_pout[31:24] = addr_ff[15:8];
        nxt_poe[31:24]  = 8'hff;
      end else begin
        nxt_pout[16]    = addr_ff[0];
        nxt_pout[23:17] = dphase ? wd[6:0] : addr_ff[7:1];
        nxt_poe[16]     = 1'b1;
        nxt_poe[23:17]  = {7{!dphase || wr_ff}};
        nxt_pout[24]    = dphase ? wd[7] : addr_ff[8];
        nxt_poe[24]     = !dphase || wr_ff;
        nxt_pout[31:25] = addr_ff[15:9];
        nxt_poe[31:25]  = 7'h7f;
      end
      nxt_pout[35:32] = (state_ff == ST_IDLE) ? ext_bus_pkg::CS_IDLE : cs_decode(space_ff);
      nxt_pout[39:36] = addr_ff[19:16];
      nxt_poe[39:32]  = 8'hff;
    end
    // strobes: rd, wrl, wrh, bhe, ale, hold_acknowledge_output, busy
    nxt_strb = 7'h2f;
    nxt_strb[4] = 1'b0;
    nxt_strb[5] = !(i_expansion_mode && state_ff == ST_HOLD);
    nxt_strb[6] = state_ff == ST_ADDR || state_ff == ST_STROBE;
    if (state_ff == ST_ADDR) begin
      nxt_strb[4] = 1'b1;
    end
    if (dphase) begin
      nxt_strb[0] = wr_ff;
      if (i_single_strobe) begin
        nxt_strb[1] = !wr_ff;
        nxt_strb[3] = !(addr_ff[0] || word_ff);
      end else begin
        nxt_strb[1] = !(wr_ff && (!addr_ff[0] || word_ff));
        nxt_strb[2] = !(wr_ff && (addr_ff[0] || word_ff));
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= ext_bus_pkg::CNT_ZERO;
      addr_ff  <= 20'h00000;
      wdat_ff  <= 16'h0000;
      wr_ff    <= 1'b0;
      word_ff  <= 1'b0;
      space_ff <= 2'h0;
      rdata_ff <= 16'h0000;
      done_ff  <= 1'b0;
      pout_ff  <= 40'h0;
      poe_ff   <= 40'h0;
      ppu_ff   <= 40'h0;
      irq_ff   <= 8'h00;
      strb_ff  <= 7'h2f;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      addr_ff  <= nxt_addr;
      wdat_ff  <= nxt_wdat;
      wr_ff    <= nxt_wr;
      word_ff  <= nxt_word;
      space_ff <= nxt_space;
      rdata_ff <= nxt_rdata;
      done_ff  <= nxt_done;
      pout_ff  <= nxt_pout;
      poe_ff   <= nxt_poe;
      ppu_ff   <= nxt_ppu;
      irq_ff   <= nxt_irq;
      strb_ff  <= nxt_strb;
    end
  end

  assign o_pin_out                   = pout_ff;
  assign o_pin_oe                    = poe_ff;
  assign o_pin_pullup                = ppu_ff;
  assign o_port_read                 = sync2_ff;
  assign o_ext_irq                   = irq_ff;
  assign o_read_strobe_n             = strb_ff[0];
  assign o_low_byte_write_strobe_n   = strb_ff[1];
  assign o_high_byte_write_strobe_n  = strb_ff[2];
  assign o_byte_high_enable_n        = strb_ff[3];
  assign o_ale                       = strb_ff[4];
  assign o_hold_acknowledge_output_n = strb_ff[5];
  assign o_cyc_busy                  = strb_ff[6];
  assign o_cyc_done                  = done_ff;
  assign o_cyc_rdata                 = rdata_ff;

endmodule

/* hdl/ext_bus_pkg.sv */
// constants for the external bus pin mapping block
package ext_bus_pkg;
  localparam int          PORT_W        = 8;
  localparam int          ADDR_W        = 20;
  localparam int          NUM_CS        = 4;
  localparam int          NIBBLE_W      = 4;
  localparam int          ALE_CYCLES    = 1;
  localparam int          STROBE_CYCLES = 2;
  localparam logic [7:0]  DIR_RESET     = 8'h00;
  localparam logic [1:0]  PULLUP_RESET  = 2'h0;
  localparam logic [7:0]  PORT_RESET    = 8'h00;
  localparam logic [3:0]  CS_IDLE       = 4'hf;
  localparam logic [1:0]  CNT_ZERO      = 2'h0;
  typedef enum logic [1:0] {
    BUS_SEPARATE,
    BUS_MUX
  } bus_form_e;
endpackage

/* verification/ext_bus_pins_asserts.sv */
// checker for the external bus pin block
`timescale 1ns/100ps
module ext_bus_pins_chk (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_expansion_mode,
  input wire logic        i_single_strobe,
  input wire logic        i_hold_req_n,
  input wire logic        i_cyc_start,
  input wire logic        i_cyc_write,
  input wire logic        i_cyc_word,
  input wire logic [19:0] i_cyc_addr,
  input wire logic [1:0]  i_cyc_space,
  input wire logic [39:0] o_pin_out,
  input wire logic [39:0] o_pin_oe,
  input wire logic [39:0] o_pin_pullup,
  input wire logic        o_read_strobe_n,
  input wire logic        o_low_byte_write_strobe_n,
  input wire logic        o_high_byte_write_strobe_n,
  input wire logic        o_byte_high_enable_n,
  input wire logic        o_ale,
  input wire logic        o_hold_acknowledge_output_n,
  input wire logic        o_cyc_busy,
  input wire logic        o_cyc_done
);
  wire logic acc = i_cyc_start && !o_cyc_busy && i_expansion_mode && i_hold_req_n && o_hold_acknowledge_output_n;
  wire logic quiet = o_read_strobe_n && o_low_byte_write_strobe_n && o_high_byte_write_strobe_n && !o_ale;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  a_reset_quiet: assert property (disable iff (1'b0) !i_rstn |=> o_pin_oe == 40'h0 && quiet
    && o_hold_acknowledge_output_n && !o_cyc_busy && !o_cyc_done) else $error("outputs active in reset");
  a_addr_phase: assert property (acc |-> ##2 o_ale && o_pin_out[31:16] == $past(i_cyc_addr[15:0], 2)
    && o_pin_out[39:36] == $past(i_cyc_addr[19:16], 2) && o_pin_out[35:32] == ~(4'h1 << $past(i_cyc_space, 2)))
    else $error("address phase wrong");
  a_read_strobe: assert property (acc && !i_cyc_write |-> ##3 !o_read_strobe_n ##1
    (!o_read_strobe_n && o_cyc_done) ##1 o_read_strobe_n) else $error("read strobe timing wrong");
  a_split_write: assert property (acc && i_cyc_write && !i_single_strobe |-> ##3 o_read_strobe_n
    && o_low_byte_write_strobe_n == ($past(i_cyc_addr[0], 3) && !$past(i_cyc_word, 3))
    && o_high_byte_write_strobe_n == (!$past(i_cyc_addr[0], 3) && !$past(i_cyc_word, 3))) else $error("split strobes wrong");
  a_single_bhe: assert property (acc && i_cyc_write && i_single_strobe |-> ##3 !o_low_byte_write_strobe_n
    && o_high_byte_write_strobe_n && o_byte_high_enable_n == !($past(i_cyc_addr[0], 3) || $past(i_cyc_word, 3)))
    else $error("single strobe wrong");
  a_hold_enter: assert property ((!i_hold_req_n && !o_cyc_busy) [*4] |-> ##[1:2] !o_hold_acknowledge_output_n)
    else $error("hold not acknowledged");
  a_hold_leave: assert property (i_hold_req_n [*6] |-> o_hold_acknowledge_output_n)
    else $error("hold acknowledge stuck");
  a_single_chip: assert property (!i_expansion_mode [*3] |-> quiet && !o_cyc_busy)
    else $error("bus activity in single chip");
  a_pullup_bus: assert property (i_expansion_mode [*3] |-> o_pin_pullup == 40'h0)
    else $error("pull-up in expansion mode");
endmodule
bind ext_bus_pins ext_bus_pins_chk chk (.*);

/* verification/ext_mem_model.sv */
// external memory on the far side of the bus pins
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic        i_clock,        // system clock
  input  wire logic        i_mux_bus,      // multiplexed form
  input  wire logic        i_bus_width_8,  // 8-bit data bus
  input  wire logic [39:0] i_pins,         // design pin levels
  input  wire logic        i_ale,          // address latch enable
  input  wire logic        i_rd_n,         // read strobe
  input  wire logic        i_wrl_n,        // low or single write
  input  wire logic        i_wrh_n,        // high write
  output logic      [39:0] o_drv           // levels driven back
);
  logic [7:0]  mem [int];
  logic [19:0] adr;
  logic [39:0] idle_ff = 40'h0;
  logic [39:0] rdv;
  function automatic logic [7:0] rd(input logic [19:0] x);
    return mem.exists(x) ? mem[x] : 8'h00;
  endfunction
  always @(posedge i_clock) begin
    idle_ff <= ~o_drv;
    if (i_ale)
      adr = {i_pins[39:36], i_pins[31:16]};
    if (!i_wrl_n)
      mem[i_bus_width_8 ? adr : {adr[19:1], 1'b0}] = i_mux_bus ? i_pins[23:16] : i_pins[7:0];
    if (!i_wrh_n)
      mem[{adr[19:1], 1'b1}] = i_pins[15:8];
  end
  always_comb begin
    rdv = idle_ff;
    if (!i_bus_width_8)
      rdv[15:0] = {rd({adr[19:1], 1'b1}), rd({adr[19:1], 1'b0})};
    else if (i_mux_bus)
      rdv[23:16] = rd(adr);
    else
      rdv[7:0] = rd(adr);
    o_drv = i_rd_n ? idle_ff : rdv;
  end
endmodule

/* verification/tb_top.sv */
// bench for the external bus pin block
`timescale 1ns/100ps
module tb_top;
  logic clock = 0, rstn = 0, w8 = 0, exp_m = 0, mux = 0, ss = 0, hold_n = 1, start = 0, wr = 0, word = 0, we = 0;
  logic [19:0] addr = 0;
  logic [15:0] wdata = 0, rdata;
  logic [1:0]  space = 0, pu = 0;
  logic [2:0]  port = 0;
  logic [7:0]  dir = 0, data = 0, irq_sel = 0, irq;
  logic [39:0] pin_in, out, oe, pull, prd, mdl, ext_en = 0, ext_drv = 0;
  logic        rd_n, wrl_n, wrh_n, ale, ack_n, busy, done;
  int          fail_count = 0, comparisons = 0;
  assign pin_in = (oe & out) | (~oe & ((ext_en & ext_drv) | (~ext_en & mdl)));
  initial forever #5 clock = ~clock;
  ext_bus_pins dut (.i_clock(clock), .i_rstn(rstn), .i_bus_width_8(w8), .i_expansion_mode(exp_m), .i_mux_bus(mux),
    .i_single_strobe(ss), .i_hold_req_n(hold_n), .i_cyc_start(start), .i_cyc_write(wr), .i_cyc_word(word),
    .i_cyc_addr(addr), .i_cyc_wdata(wdata), .i_cyc_space(space), .i_cfg_we(we), .i_cfg_port(port), .i_cfg_dir(dir),
    .i_cfg_data(data), .i_cfg_pullup(pu), .i_irq_sel(irq_sel), .i_pin_in(pin_in), .o_pin_out(out), .o_pin_oe(oe),
    .o_pin_pullup(pull), .o_port_read(prd), .o_ext_irq(irq), .o_read_strobe_n(rd_n), .o_low_byte_write_strobe_n(wrl_n),
    .o_high_byte_write_strobe_n(wrh_n), .o_byte_high_enable_n(), .o_ale(ale), .o_hold_acknowledge_output_n(ack_n),
    .o_cyc_busy(busy), .o_cyc_done(done), .o_cyc_rdata(rdata));
  ext_mem_model mem (.i_clock(clock), .i_mux_bus(mux), .i_bus_width_8(w8), .i_pins(out), .i_ale(ale), .i_rd_n(rd_n),
    .i_wrl_n(wrl_n), .i_wrh_n(wrh_n), .o_drv(mdl));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cfg(input logic [2:0] p, input logic [7:0] d, input logic [7:0] v, input logic [1:0] u);
    @(posedge clock);
    we <= 1;
    port <= p;
    dir <= d;
    data <= v;
    pu <= u;
    @(posedge clock);
    we <= 0;
  endtask
  // ok low: the start is expected to be ignored
  task automatic cyc(input logic w, input logic wd, input logic [19:0] a, input logic [15:0] d, input logic [1:0] s,
                     input logic ok);
    int n;
    @(posedge clock);
    start <= 1;
    wr <= w;
    word <= wd;
    addr <= a;
    wdata <= d;
    space <= s;
    @(posedge clock);
    start <= 0;
    #1;
    for (n = 0; ok && done !== 1'b1; n++) begin
      if (n == 20) begin
        fail_count++;
        conclude();
      end
      tick(1);
    end
    if (!ok) begin
      tick(6);
      chk("busy", 40'h0, busy);
    end
  endtask
  initial begin
    tick(5);
    rstn <= 1;
    tick(3);
    chk("oe", 40'h0, oe);
    chk("strobes", 40'h7, {rd_n, wrl_n, wrh_n});
    for (int p = 0; p < 6; p++)
      cfg(p[2:0], p == 5 ? 8'hff : 8'h0f, 8'ha5, 2'h2);
    tick(3);
    for (int p = 0; p < 5; p++) begin
      chk("oe", 40'h0f, oe[8*p+:8]);
      chk("out", 40'h05, out[8*p+:8] & 8'h0f);
      chk("pullup", 40'hf0, pull[8*p+:8]);
    end
    ext_en <= 40'hff00;
    ext_drv <= 40'h3c00;
    irq_sel <= 8'hff;
    tick(5);
    chk("irq", 40'h30, irq);
    chk("read", 40'h35, prd[15:8]);
    cyc(1, 1, 20'h12344, 16'h1111, 0, 0);
    $display("test single chip done");
    exp_m <= 1;
    ext_en <= 0;
    irq_sel <= 0;
    tick(3);
    cyc(1, 1, 20'h12344, 16'hbeef, 2, 1);
    cyc(1, 0, 20'h12347, 16'h5a5a, 1, 1);
    cyc(0, 1, 20'h12344, 16'h0, 0, 1);
    chk("rdata", 40'hbeef, rdata);
    cyc(0, 1, 20'h12346, 16'h0, 3, 1);
    chk("rdata", 40'h5a00, rdata);
    cyc(0, 0, 20'h12345, 16'h0, 3, 1);
    chk("rdata", 40'hbe, rdata[7:0]);
    $display("test separate bus done");
    w8 <= 1;
    mux <= 1;
    ss <= 1;
    cyc(1, 0, 20'h0a5c3, 16'h0077, 0, 1);
    cyc(0, 0, 20'h0a5c3, 16'h0, 3, 1);
    chk("rdata", 40'h77, rdata[7:0]);
    w8 <= 0;
    ss <= 0;
    cyc(1, 1, 20'hf0f0e, 16'h1234, 3, 1);
    $display("test multiplexed bus done");
    hold_n <= 0;
    tick(6);
    chk("ack", 40'h0, ack_n);
    cyc(1, 1, 20'h00010, 16'h0, 0, 0);
    hold_n <= 1;
    tick(6);
    chk("ack", 40'h1, ack_n);
    $display("test hold done");
    conclude();
  end
endmodule
